// File: hw/bcsr_consts.svh
// Purpose: Offsets, field positions and reset values of the register slice
// Assumes: 8-bit registers behind the serial register port
// Notes: Definitions only
`ifndef BCSR_CONSTS_SVH
`define BCSR_CONSTS_SVH

`define BCSR_OFS_CTRL 8'h04
`define BCSR_OFS_OP 8'h05
`define BCSR_OFS_FLT 8'h06
`define BCSR_CTRL_RST 8'h42
`define BCSR_OP_RST 8'h00
`define BCSR_FLT_RST 8'h00
`define BCSR_RD_NONE 8'h00

`define BCSR_TRIM_HI 7
`define BCSR_TRIM_LO 5
`define BCSR_BST 4
`define BCSR_SW 3
`define BCSR_DSC 2
`define BCSR_DET 1
`define BCSR_FLAG 0
`define BCSR_UVB 7

// Step-up target in mV: base 5200, weights -100, -50, +25
`define BCSR_MV_BASE 13'h1450
`define BCSR_MV_W2 13'h0064
`define BCSR_MV_W1 13'h0032
`define BCSR_MV_W0 13'h0019
`define BCSR_MV_NONE 13'h0000
`define BCSR_MV_DEFAULT 13'h141e

`define BCSR_BYTE_BITS 4'h8
`define BCSR_DEV_ADDR 7'h2a
`define BCSR_LINE_IDLE 1'b1

`endif

// File: hw/bcsr_pkg.sv
// Purpose: Types shared by the register slice and its serial port
// Assumes: Nothing
// Notes: Constants live in bcsr_consts.svh
package bcsr_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_wr,
    st_sack,
    st_rd,
    st_mack
  } bcsr_i2c_st_t;
endpackage

// File: hw/bcsr_i2c_slave.sv
// Purpose: Serial two-wire register port, one register byte at a time
// Assumes: SCL and SDA are far slower than the core clock
// Notes: First written byte is the register pointer; it auto-increments
`include "bcsr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module bcsr_i2c_slave
  import bcsr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `BCSR_DEV_ADDR
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oen_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_stb_o,
  output logic rd_stb_o,
  input wire logic [7:0] rdata_i
);
  logic scl1_ff, scl2_ff, scl3_ff, sda1_ff, sda2_ff, sda3_ff;
  logic rise, fall, start, stop;
  bcsr_i2c_st_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh, tx_ff, nxt_tx, addr_ff, nxt_addr;
  logic oen_ff, nxt_oen, rw_ff, nxt_rw, ptr_ff, nxt_ptr;
  logic wr_ff, nxt_wr, rd_ff, nxt_rd;

  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      scl1_ff <= `BCSR_LINE_IDLE;
      scl2_ff <= `BCSR_LINE_IDLE;
      scl3_ff <= `BCSR_LINE_IDLE;
      sda1_ff <= `BCSR_LINE_IDLE;
      sda2_ff <= `BCSR_LINE_IDLE;
      sda3_ff <= `BCSR_LINE_IDLE;
    end
    else
    begin
      scl1_ff <= scl_i;
      scl2_ff <= scl1_ff;
      scl3_ff <= scl2_ff;
      sda1_ff <= sda_i;
      sda2_ff <= sda1_ff;
      sda3_ff <= sda2_ff;
    end

  assign rise = scl2_ff & ~scl3_ff;
  assign fall = ~scl2_ff & scl3_ff;
  assign start = scl2_ff & scl3_ff & sda3_ff & ~sda2_ff;
  assign stop = scl2_ff & scl3_ff & ~sda3_ff & sda2_ff;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_tx = tx_ff;
    nxt_addr = addr_ff;
    nxt_oen = oen_ff;
    nxt_rw = rw_ff;
    nxt_ptr = ptr_ff;
    nxt_wr = 1'b0;
    nxt_rd = 1'b0;
    if (wr_ff | rd_ff)
      nxt_addr = addr_ff + 8'h01;
    if (stop)
    begin
      nxt_st = st_idle;
      nxt_oen = 1'b1;
    end
    else if (start)
    begin
      nxt_st = st_addr;
      nxt_cnt = 4'h0;
      nxt_oen = 1'b1;
    end
    else
      case (st_ff)
        st_addr, st_wr:
          if (rise)
          begin
            nxt_sh = {sh_ff[6:0], sda2_ff};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (fall && cnt_ff == `BCSR_BYTE_BITS)
          begin
            nxt_oen = 1'b0;
            nxt_st = st_sack;
            if (st_ff == st_addr)
            begin
              nxt_rw = sh_ff[0];
              nxt_ptr = ~sh_ff[0];
              if (sh_ff[7:1] != DEV_ADDR)
              begin
                nxt_oen = 1'b1;
                nxt_st = st_idle;
              end
            end
            else if (ptr_ff)
            begin
              nxt_addr = sh_ff;
              nxt_ptr = 1'b0;
            end
            else
              nxt_wr = 1'b1;
          end
        st_sack:
          if (fall)
          begin
            nxt_oen = 1'b1;
            nxt_cnt = 4'h0;
            nxt_st = rw_ff ? st_rd : st_wr;
            nxt_rd = rw_ff;
          end
        st_rd:
          // Byte is taken in the cycle the read strobe is high, before the pointer increments
          if (rd_ff)
          begin
            nxt_tx = rdata_i;
            nxt_oen = rdata_i[7];
            nxt_cnt = 4'h1;
          end
          else if (fall && cnt_ff == `BCSR_BYTE_BITS)
          begin
            nxt_oen = 1'b1;
            nxt_st = st_mack;
          end
          else if (fall)
          begin
            nxt_tx = {tx_ff[6:0], 1'b0};
            nxt_oen = tx_ff[6];
            nxt_cnt = cnt_ff + 4'h1;
          end
        st_mack:
          if (rise && sda2_ff)
            nxt_st = st_idle;
          else if (fall)
          begin
            nxt_rd = 1'b1;
            nxt_cnt = 4'h0;
            nxt_st = st_rd;
          end
        default:
          nxt_st = st_idle;
      endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      st_ff <= st_idle;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'h00;
      addr_ff <= 8'h00;
      oen_ff <= 1'b1;
      rw_ff <= 1'b0;
      ptr_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      tx_ff <= nxt_tx;
      addr_ff <= nxt_addr;
      oen_ff <= nxt_oen;
      rw_ff <= nxt_rw;
      ptr_ff <= nxt_ptr;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end

  assign sda_oen_o = oen_ff;
  assign addr_o = addr_ff;
  assign wdata_o = sh_ff;
  assign wr_stb_o = wr_ff;
  assign rd_stb_o = rd_ff;
endmodule
`default_nettype wire

// File: hw/bcsr_regs.sv
// Purpose: Boost control register and operating/fault status registers
// Assumes: Analog comparator and status levels arrive unsynchronised
// Notes: Registers reached only through the serial two-wire port
//
// Operation
// (R1) Trim: 5.2V base, -100/-50/+25mV, default 5.15V
// (R2) Boost runs only when enabled, input below 2V
// (R3) Switch enable drives pass switch, resets off
// (R4) Discharge bit connects output discharge path
// (R5) Detect enable defaults on; toggle to rearm
// (R6) Arm at 90 percent, flag at 75 percent
// (R7) Write one clears attach flag; host clears
// (R8) Any operating status change raises interrupt
// (R9) Any fault status change raises interrupt
// (R10) Operating state field reports current mode
// (R11) Charge phase field reports charging stage
// (R12) Input voltage and current limiting flags
// (R13) Input present: above both lows, below overvoltage
// (R14) Battery undervoltage sets, clears after recharge
// (R15) Output short flag reports detected short
// (R16) Step-up limit flag reports current limiting
// (R17) Charge fault code reports fault cause
// (R18) Thermistor zone code reports temperature zone
// (R19) Register reset restores all power-on values
// (R20) Interrupt holds until changed register read
`include "bcsr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module bcsr_regs
  import bcsr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `BCSR_DEV_ADDR
)
(
  input wire logic CORE_CLK_I,
  input wire logic ARST_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output var logic SDA_O,
  output var logic SDA_OEN_O,
  output var logic INT_N_O,
  input wire logic REG_RST_I,
  input wire logic VIN_LOW_I,
  input wire logic OUT_ABOVE90_I,
  input wire logic OUT_BELOW75_I,
  input wire logic [1:0] OP_STATE_I,
  input wire logic [1:0] CHARGE_PHASE_I,
  input wire logic INPUT_VOLTAGE_LIMITING_I,
  input wire logic INPUT_CURRENT_LIMITING_I,
  input wire logic VIN_ABOVE_UV_I,
  input wire logic VIN_ABOVE_HEADROOM_I,
  input wire logic VIN_BELOW_OV_I,
  input wire logic BATT_LOCKOUT_I,
  input wire logic BATT_RECHARGED_I,
  input wire logic OUTPUT_SHORT_I,
  input wire logic STEP_UP_LIMIT_I,
  input wire logic [1:0] CHARGE_FAULT_CODE_I,
  input wire logic [2:0] THERMISTOR_ZONE_CODE_I,
  output var logic [2:0] STEP_UP_VOLTAGE_TRIM_O,
  output var logic [12:0] STEP_UP_TARGET_MV_O,
  output var logic STEP_UP_RUN_O,
  output var logic OUTPUT_PASS_SWITCH_O,
  output var logic OUTPUT_DISCHARGE_ENABLE_O,
  output var logic PORT_TWO_ATTACH_FLAG_O
);
  localparam int SYNC_W = 21;
  logic [SYNC_W-1:0] raw, s1_ff, s2_ff;
  logic vin_low, a90, b75, vlim, ilim, uv_ok, hd_ok, ov_ok;
  logic lock, rechg, short_s, lim_s;
  logic [1:0] opst, phase, cfault;
  logic [2:0] tzone;
  logic [7:0] addr, wdata, rdata;
  logic wr_stb, rd_stb, wr_ctrl, rd_op, rd_flt;
  logic [7:0] ctrl_ff, nxt_ctrl, op_ff, nxt_op, flt_ff, nxt_flt;
  logic arm_ff, nxt_arm, done_ff, nxt_done, uvb_ff, nxt_uvb, attach_set;
  logic pend_op_ff, nxt_pend_op, pend_flt_ff, nxt_pend_flt, op_chg, flt_chg;
  logic int_n_ff, nxt_int_n, run_ff, nxt_run;
  logic [12:0] mv_ff, nxt_mv;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] o);
    reg_hit = (a == o);
  endfunction

  function automatic logic [12:0] trim_mv(input logic [2:0] t);
    trim_mv = `BCSR_MV_BASE - (t[2] ? `BCSR_MV_W2 : `BCSR_MV_NONE)
            - (t[1] ? `BCSR_MV_W1 : `BCSR_MV_NONE)
            + (t[0] ? `BCSR_MV_W0 : `BCSR_MV_NONE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Every analog level goes through two flops before use
  assign raw = {VIN_LOW_I, OUT_ABOVE90_I, OUT_BELOW75_I, OP_STATE_I,
                CHARGE_PHASE_I, INPUT_VOLTAGE_LIMITING_I,
                INPUT_CURRENT_LIMITING_I, VIN_ABOVE_UV_I,
                VIN_ABOVE_HEADROOM_I, VIN_BELOW_OV_I, BATT_LOCKOUT_I,
                BATT_RECHARGED_I, OUTPUT_SHORT_I, STEP_UP_LIMIT_I,
                CHARGE_FAULT_CODE_I, THERMISTOR_ZONE_CODE_I};

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    if (!ARST_N_I)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
    end
    else
    begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
    end

  assign {vin_low, a90, b75, opst, phase, vlim, ilim, uv_ok, hd_ok, ov_ok,
          lock, rechg, short_s, lim_s, cfault, tzone} = s2_ff;

  bcsr_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_port (
    .clk_i(CORE_CLK_I),
    .arst_n_i(ARST_N_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .sda_oen_o(SDA_OEN_O),
    .addr_o(addr),
    .wdata_o(wdata),
    .wr_stb_o(wr_stb),
    .rd_stb_o(rd_stb),
    .rdata_i(rdata)
  );

  assign wr_ctrl = wr_stb & reg_hit(addr, `BCSR_OFS_CTRL);
  assign rd_op = rd_stb & reg_hit(addr, `BCSR_OFS_OP);
  assign rd_flt = rd_stb & reg_hit(addr, `BCSR_OFS_FLT);
  assign rdata = reg_hit(addr, `BCSR_OFS_CTRL) ? ctrl_ff :
                 reg_hit(addr, `BCSR_OFS_OP) ? op_ff :
                 reg_hit(addr, `BCSR_OFS_FLT) ? flt_ff : `BCSR_RD_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Control register and port-two attach detector
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_arm = arm_ff;
    nxt_done = done_ff;
    attach_set = 1'b0;
    if (wr_ctrl)
    begin
      nxt_ctrl[`BCSR_TRIM_HI:`BCSR_DET] = wdata[`BCSR_TRIM_HI:`BCSR_DET];
      if (wdata[`BCSR_FLAG])
        nxt_ctrl[`BCSR_FLAG] = 1'b0; // R7
    end
    // One detection per enable pulse, so the host must toggle to rearm
    if (!ctrl_ff[`BCSR_DET])
    begin
      nxt_arm = 1'b0; // R5
      nxt_done = 1'b0;
    end
    else if (!done_ff && !arm_ff && a90)
      nxt_arm = 1'b1; // R6
    else if (arm_ff && b75)
    begin
      nxt_arm = 1'b0; // R6
      nxt_done = 1'b1; // R5
      attach_set = 1'b1;
    end
    if (attach_set)
      nxt_ctrl[`BCSR_FLAG] = 1'b1; // R7
    nxt_run = ctrl_ff[`BCSR_BST] & vin_low; // R2
    nxt_mv = trim_mv(ctrl_ff[`BCSR_TRIM_HI:`BCSR_TRIM_LO]); // R1
    if (REG_RST_I)
    begin
      nxt_ctrl = `BCSR_CTRL_RST; // R19
      nxt_arm = 1'b0;
      nxt_done = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status registers and change interrupt
  always_comb
  begin
    nxt_uvb = uvb_ff;
    if (lock)
      nxt_uvb = 1'b1; // R14
    else if (rechg)
      nxt_uvb = 1'b0; // R14
    nxt_op = {opst, phase, vlim, ilim, // R10 R11 R12
              uv_ok & hd_ok & ov_ok, 1'b0}; // R13
    nxt_flt = {nxt_uvb, short_s, lim_s, cfault, tzone}; // R15 R16 R17 R18
    op_chg = (nxt_op != op_ff);
    flt_chg = (nxt_flt != flt_ff);
    // A change in the read cycle keeps the interrupt pending
    nxt_pend_op = op_chg | (pend_op_ff & ~rd_op); // R8 R20
    nxt_pend_flt = flt_chg | (pend_flt_ff & ~rd_flt); // R9 R20
    if (REG_RST_I)
    begin
      nxt_uvb = 1'b0; // R19
      nxt_op = `BCSR_OP_RST;
      nxt_flt = `BCSR_FLT_RST;
      nxt_pend_op = 1'b0;
      nxt_pend_flt = 1'b0;
    end
    nxt_int_n = ~(nxt_pend_op | nxt_pend_flt);
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    if (!ARST_N_I)
    begin
      ctrl_ff <= `BCSR_CTRL_RST;
      arm_ff <= 1'b0;
      done_ff <= 1'b0;
      run_ff <= 1'b0;
      mv_ff <= `BCSR_MV_DEFAULT;
      uvb_ff <= 1'b0;
      op_ff <= `BCSR_OP_RST;
      flt_ff <= `BCSR_FLT_RST;
      pend_op_ff <= 1'b0;
      pend_flt_ff <= 1'b0;
      int_n_ff <= 1'b1;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      arm_ff <= nxt_arm;
      done_ff <= nxt_done;
      run_ff <= nxt_run;
      mv_ff <= nxt_mv;
      uvb_ff <= nxt_uvb;
      op_ff <= nxt_op;
      flt_ff <= nxt_flt;
      pend_op_ff <= nxt_pend_op;
      pend_flt_ff <= nxt_pend_flt;
      int_n_ff <= nxt_int_n;
    end

  // Open-drain data line: only ever pulled low
  assign SDA_O = 1'b0;
  assign INT_N_O = int_n_ff;
  assign STEP_UP_VOLTAGE_TRIM_O = ctrl_ff[`BCSR_TRIM_HI:`BCSR_TRIM_LO];
  assign STEP_UP_TARGET_MV_O = mv_ff;
  assign STEP_UP_RUN_O = run_ff;
  assign OUTPUT_PASS_SWITCH_O = ctrl_ff[`BCSR_SW]; // R3
  assign OUTPUT_DISCHARGE_ENABLE_O = ctrl_ff[`BCSR_DSC]; // R4
  assign PORT_TWO_ATTACH_FLAG_O = ctrl_ff[`BCSR_FLAG];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence rst_then_quiet;
    REG_RST_I ##1 !wr_ctrl;
  endsequence
  sequence armed_drop;
    arm_ff && b75 && !REG_RST_I && ctrl_ff[`BCSR_DET];
  endsequence

  a_trim_default: assert property (rst_then_quiet |=> // R1
    STEP_UP_TARGET_MV_O == `BCSR_MV_DEFAULT)
    else $error("step-up target not 5150 mV after reset");
  a_boost_gate: assert property (!vin_low |=> !STEP_UP_RUN_O) // R2
    else $error("step-up ran with input not low");
  a_switch_write: assert property (wr_ctrl && !REG_RST_I |=> // R3
    OUTPUT_PASS_SWITCH_O == $past(wdata[`BCSR_SW]))
    else $error("pass switch did not follow write");
  a_discharge_write: assert property (wr_ctrl && !REG_RST_I |=> // R4
    OUTPUT_DISCHARGE_ENABLE_O == $past(wdata[`BCSR_DSC]))
    else $error("discharge path did not follow write");
  a_detect_once: assert property ($rose(done_ff) |-> !arm_ff // R5
    ##1 (!arm_ff || !$past(done_ff)))
    else $error("detector rearmed without toggle");
  a_attach_set: assert property (armed_drop |=> // R6
    PORT_TWO_ATTACH_FLAG_O ##1 PORT_TWO_ATTACH_FLAG_O || $past(wr_ctrl)
    || $past(REG_RST_I))
    else $error("attach flag not set on drop");
  a_flag_clear: assert property (wr_ctrl && wdata[`BCSR_FLAG] && // R7
    !attach_set && !REG_RST_I |=> !PORT_TWO_ATTACH_FLAG_O)
    else $error("attach flag not cleared by write one");
  a_op_irq: assert property (op_ff != $past(op_ff) && // R8
    !$past(REG_RST_I) |-> pend_op_ff && !INT_N_O)
    else $error("operating change without interrupt");
  a_flt_irq: assert property (flt_ff != $past(flt_ff) && // R9
    !$past(REG_RST_I) |-> pend_flt_ff && !INT_N_O)
    else $error("fault change without interrupt");
  a_present_and: assert property (!REG_RST_I |=> // R13
    op_ff[1] == $past(uv_ok && hd_ok && ov_ok))
    else $error("input present flag wrong");
  a_uv_hold: assert property (uvb_ff && !rechg && !REG_RST_I |=> // R14
    flt_ff[`BCSR_UVB])
    else $error("battery undervoltage flag dropped early");
  a_reg_reset: assert property (REG_RST_I |=> // R19
    ctrl_ff == `BCSR_CTRL_RST && op_ff == `BCSR_OP_RST &&
    flt_ff == `BCSR_FLT_RST && INT_N_O)
    else $error("register reset incomplete");
  a_read_clear: assert property (rd_op && !op_chg && !pend_flt_ff && // R20
    !flt_chg |=> INT_N_O)
    else $error("interrupt held after status read");
  a_run_follow: assert property (ctrl_ff[`BCSR_BST] && vin_low |=> // R2
    STEP_UP_RUN_O)
    else $error("step-up not run with enable and low input");
  a_attach_armed: assert property ($rose(PORT_TWO_ATTACH_FLAG_O) |-> // R6
    $past(arm_ff) && $past(b75))
    else $error("attach flag set without armed drop");
  a_op_fields: assert property (!REG_RST_I |=> // R10 R11 R12
    op_ff[7:2] == {$past(opst), $past(phase), $past(vlim), $past(ilim)})
    else $error("operating status fields wrong");
  a_fault_fields: assert property (!REG_RST_I |=> // R15 R16 R17 R18
    flt_ff[6:0] == {$past(short_s), $past(lim_s), $past(cfault),
    $past(tzone)})
    else $error("fault status fields wrong");
endmodule
`default_nettype wire

// File: test/bcsr_host_model.sv
// Purpose: Two-wire host that reads and writes the register slice
// Assumes: Line has a pull-up; host only ever pulls SDA low
// Notes: Phases of five or ten core cycles keep well above the port's minimum
`timescale 1ns/1ps
`default_nettype none
`include "bcsr_consts.svh"
module bcsr_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bit level; SDA only moves while SCL is low, except in start and stop
  task automatic start_cond();
    scl_o = 1'b0;
    wait_clk(5);
    sda_pull_o = 1'b0;
    wait_clk(5);
    scl_o = 1'b1;
    wait_clk(10);
    sda_pull_o = 1'b1;
    wait_clk(10);
    scl_o = 1'b0;
  endtask

  task automatic stop_cond();
    scl_o = 1'b0;
    sda_pull_o = 1'b1;
    wait_clk(5);
    scl_o = 1'b1;
    wait_clk(10);
    sda_pull_o = 1'b0;
    wait_clk(10);
  endtask

  task automatic put_bit(input logic b);
    wait_clk(5);
    sda_pull_o = ~b;
    wait_clk(5);
    scl_o = 1'b1;
    wait_clk(10);
    scl_o = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    sda_pull_o = 1'b0;
    wait_clk(10);
    scl_o = 1'b1;
    wait_clk(5);
    b = sda_i;
    wait_clk(5);
    scl_o = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Byte level and register transfers
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask

  task automatic recv_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(last);
  endtask

  task automatic write_reg(input logic [7:0] a, d, output logic ok);
    logic k1, k2, k3;
    start_cond();
    send_byte({`BCSR_DEV_ADDR, 1'b0}, k1);
    send_byte(a, k2);
    send_byte(d, k3);
    stop_cond();
    ok = k1 & k2 & k3;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    logic k1, k2, k3;
    start_cond();
    send_byte({`BCSR_DEV_ADDR, 1'b0}, k1);
    send_byte(a, k2);
    start_cond();
    send_byte({`BCSR_DEV_ADDR, 1'b1}, k3);
    recv_byte(d, 1'b1);
    stop_cond();
    ok = k1 & k2 & k3;
  endtask
endmodule
`default_nettype wire

// File: test/bcsr_regs_tb_top.sv
// Purpose: Self-checking bench for the boost control and status slice
// Assumes: Analog comparators modelled as plain levels
// Notes: Random values from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module bcsr_regs_tb_top;
  logic clk, arst_n, rst_cmd, vin_low, a90, b75, vlim, ilim, uvok, hr, ov;
  logic lock, rech, shrt, blim, host_pull, sda_oen, int_n, ok, sw, dsc;
  logic run, flag, uv_exp;
  logic [1:0] op_st, phase, fcode;
  logic [2:0] zone, trim;
  logic [12:0] tgt;
  logic [7:0] d, rd;
  logic [31:0] seed;
  int err_count, tests_run, cyc;
  wire logic scl;
  wire logic sda;
  // Open-drain line with pull-up
  assign sda = ~(host_pull | ~sda_oen);

  bcsr_host_model bcsr_host_model_i (.clk_i(clk), .sda_i(sda),
    .scl_o(scl), .sda_pull_o(host_pull));

  bcsr_regs bcsr_regs_i (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .SCL_I(scl),
    .SDA_I(sda), .SDA_O(), .SDA_OEN_O(sda_oen), .INT_N_O(int_n),
    .REG_RST_I(rst_cmd), .VIN_LOW_I(vin_low), .OUT_ABOVE90_I(a90),
    .OUT_BELOW75_I(b75), .OP_STATE_I(op_st), .CHARGE_PHASE_I(phase),
    .INPUT_VOLTAGE_LIMITING_I(vlim), .INPUT_CURRENT_LIMITING_I(ilim),
    .VIN_ABOVE_UV_I(uvok), .VIN_ABOVE_HEADROOM_I(hr), .VIN_BELOW_OV_I(ov),
    .BATT_LOCKOUT_I(lock), .BATT_RECHARGED_I(rech), .OUTPUT_SHORT_I(shrt),
    .STEP_UP_LIMIT_I(blim), .CHARGE_FAULT_CODE_I(fcode),
    .THERMISTOR_ZONE_CODE_I(zone), .STEP_UP_VOLTAGE_TRIM_O(trim),
    .STEP_UP_TARGET_MV_O(tgt), .STEP_UP_RUN_O(run),
    .OUTPUT_PASS_SWITCH_O(sw), .OUTPUT_DISCHARGE_ENABLE_O(dsc),
    .PORT_TWO_ATTACH_FLAG_O(flag));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers and expectations
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic c, input string m);
    tests_run++;
    if (c !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  task automatic nclk(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rnd();
    seed = lfsr(seed);
  endtask

  task automatic wr(input logic [7:0] a, v);
    bcsr_host_model_i.write_reg(a, v, ok);
    chk(ok, "write not acknowledged");
  endtask

  task automatic rd_chk(input logic [7:0] a, e, input string m);
    bcsr_host_model_i.read_reg(a, rd, ok);
    chk(ok && rd === e, m);
  endtask

  // Drive output above 90 percent, then down to 75 percent
  task automatic plug_event();
    a90 = 1'b1;
    nclk(6);
    a90 = 1'b0;
    b75 = 1'b1;
    nclk(6);
    b75 = 1'b0;
    nclk(2);
  endtask

  function automatic logic [12:0] mv(input logic [2:0] t);
    return 13'h1450 - (t[2] ? 13'h0064 : 13'h0000)
      - (t[1] ? 13'h0032 : 13'h0000) + (t[0] ? 13'h0019 : 13'h0000);
  endfunction

  function automatic logic [7:0] exp_op();
    return {op_st, phase, vlim, ilim, uvok & hr & ov, 1'b0};
  endfunction

  function automatic logic [7:0] exp_flt();
    return {uv_exp, shrt, blim, fcode, zone};
  endfunction

  task automatic chk_ctrl_reset();
    chk(trim === 3'h2 && tgt === 13'h141e, "trim reset");
    chk(run === 1'b0 && sw === 1'b0, "boost or switch on");
    chk(dsc === 1'b0 && flag === 1'b0, "discharge or flag set");
  endtask

  // Bound on the whole run; tests need about 25000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t run did not finish", $time);
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {arst_n, rst_cmd, vin_low, a90, b75, vlim, ilim, uvok, hr, ov} = 10'h000;
    {lock, rech, shrt, blim, op_st, phase, fcode, zone} = 13'h0000;
    {err_count, tests_run, cyc} = {32'h0, 32'h0, 32'h0};
    seed = 32'h807b;
    uv_exp = 1'b0;
    nclk(16);
    arst_n = 1'b1;
    nclk(10);
    chk_ctrl_reset();
    chk(int_n === 1'b1, "interrupt after reset");
    rd_chk(8'h04, 8'h42, "control reset value");
    // Attach detection, clear, single shot, rearm
    plug_event();
    chk(flag === 1'b1, "attach not flagged");
    rd_chk(8'h04, 8'h43, "attach flag readback");
    wr(8'h04, 8'h43);
    chk(flag === 1'b0, "write one did not clear");
    plug_event();
    chk(flag === 1'b0, "second detect without rearm");
    wr(8'h04, 8'h40);
    wr(8'h04, 8'h42);
    plug_event();
    chk(flag === 1'b1, "rearm failed");
    wr(8'h04, 8'h43);
    // Control writes, corners first
    for (int i = 0; i < 5; i++)
    begin
      rnd();
      d = (i == 0) ? 8'hfe : (i == 1) ? 8'h1c : {seed[7:1], 1'b0};
      vin_low = (i == 1) ? 1'b1 : seed[8];
      wr(8'h04, d);
      rd_chk(8'h04, d, "control readback");
      chk(trim === d[7:5] && tgt === mv(d[7:5]), "trim");
      chk(sw === d[3] && dsc === d[2], "switch or discharge");
      chk(run === (d[4] & vin_low), "boost run");
      vin_low = ~vin_low;
      nclk(6);
      chk(run === (d[4] & vin_low), "boost run after input");
    end
    // Status changes, interrupt and read clear
    for (int i = 0; i < 6; i++)
    begin
      rnd();
      {op_st, phase, ilim, uvok, hr, ov} = seed[7:0];
      vlim = ~vlim;
      hr = hr | (i == 0);
      {uvok, ov} = (i == 0) ? 2'h3 : {uvok, ov};
      nclk(8);
      chk(int_n === 1'b0, "no interrupt on operating change");
      rd_chk(8'h05, exp_op(), "operating status");
      chk(int_n === 1'b1, "interrupt held after read");
      rnd();
      {lock, rech, blim, fcode} = seed[4:0];
      shrt = ~shrt;
      zone = seed[7:5] % 3'h5;
      uv_exp = lock ? 1'b1 : (rech ? 1'b0 : uv_exp);
      nclk(8);
      chk(int_n === 1'b0, "no interrupt on fault change");
      rd_chk(8'h06, exp_flt(), "fault status");
      chk(int_n === 1'b1, "interrupt held after read");
    end
    // Read-only, unmapped and foreign address
    wr(8'h05, 8'hff);
    rd_chk(8'h05, exp_op(), "read-only register written");
    rd_chk(8'h09, 8'h00, "unmapped read");
    bcsr_host_model_i.start_cond();
    bcsr_host_model_i.send_byte(8'h22, ok);
    bcsr_host_model_i.stop_cond();
    chk(ok === 1'b0, "foreign address acknowledged");
    // Register reset command
    wr(8'h04, 8'hbd);
    rst_cmd = 1'b1;
    nclk(1);
    rst_cmd = 1'b0;
    nclk(2);
    chk_ctrl_reset();
    rd_chk(8'h04, 8'h42, "control after register reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
